// ---- src/dcd_pkg.sv ----
package dcd_pkg;

  // ****************************************
  // Command addresses
  // ****************************************
  localparam logic [7:0] OP_REINIT = 8'h01;
  localparam logic [7:0] OP_INDIC = 8'h02;
  localparam logic [7:0] OP_SYNTH = 8'h03;
  localparam logic [7:0] OP_IN_TUNE = 8'h10;
  localparam logic [7:0] OP_OUT_TUNE = 8'h11;
  localparam logic [7:0] OP_LO_TUNE = 8'h12;
  localparam logic [7:0] OP_PREAMP = 8'h14;
  localparam logic [7:0] OP_ATTEN = 8'h15;
  localparam logic [7:0] OP_ROUTE = 8'h16;
  localparam logic [7:0] OP_SAVE = 8'h18;
  localparam logic [7:0] OP_POWER = 8'h19;
  localparam logic [7:0] OP_REFSRC = 8'h1A;
  localparam logic [7:0] OP_TRIM = 8'h1B;
  localparam logic [7:0] OP_UNVM_WR = 8'h1C;
  localparam logic [7:0] OP_GAIN = 8'h1D;
  localparam logic [7:0] OP_CAL = 8'h1F;
  localparam logic [7:0] OP_Q_PARAM = 8'h30;
  localparam logic [7:0] OP_Q_TEMP = 8'h31;
  localparam logic [7:0] OP_Q_COND = 8'h32;
  localparam logic [7:0] OP_Q_IDENT = 8'h33;
  localparam logic [7:0] OP_FNVM_RD = 8'h34;
  localparam logic [7:0] OP_UNVM_RD = 8'h35;
  localparam logic [7:0] OP_PAD = 8'h36;

  // ****************************************
  // Frame lengths, answer sizes
  // ****************************************
  localparam logic [2:0] LEN_0 = 3'h0;
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_5 = 3'h5;
  localparam logic [2:0] LEN_7 = 3'h7;
  localparam logic [3:0] ANS_ACK = 4'h1;
  localparam logic [3:0] ANS_RESP = 4'h8;
  localparam logic [7:0] ACK_BYTE = 8'h00;
  localparam logic [2:0] LAST_BYTE = 3'h7;

  // ****************************************
  // Field positions inside a payload
  // ****************************************
  localparam int B_MODE = 0;
  localparam int B_FAST = 2;
  localparam int B_BYPASS = 0;
  localparam int B_AMPPWR = 1;
  localparam int B_IFOUT = 2;
  localparam int B_NOINV = 3;
  localparam int B_EXTLOCK = 0;
  localparam int B_EXPORT = 1;
  localparam int B_AUTOAMP = 1;
  localparam int LG_LSB = 0;
  localparam int LG_W = 2;
  localparam int LIN_LSB = 2;
  localparam int LIN_W = 3;
  localparam int ATT_TGT_LSB = 8;
  localparam int ATT_TGT_W = 3;
  localparam int BYTE_W = 8;
  localparam int WORD16_W = 16;
  localparam int NVM_ADDR_LSB = 8;
  localparam int LVL_IN_LSB = 8;
  localparam int LVL_MIX_LSB = 16;
  localparam int LVL_OUT_LSB = 24;
  localparam int QSEL_W = 4;
  localparam int TUNE_W = 56;
  localparam logic [2:0] ATT_IN = 3'h0;
  localparam logic [2:0] ATT_OUT = 3'h1;
  localparam logic [3:0] QP_IN = 4'h0;
  localparam logic [3:0] QP_OUT = 4'h1;
  localparam logic [3:0] QP_LO = 4'h2;
  localparam logic [3:0] QP_OTHER = 4'h3;
  localparam logic [3:0] QI_SERIAL = 4'h0;
  localparam logic [3:0] QI_REV = 4'h1;
  localparam logic [3:0] QI_DATES = 4'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic indicator;
    logic [1:0] loop_gain;
    logic fast_tune;
    logic [55:0] input_tune_word;
    logic [55:0] output_band_tune_word;
    logic [55:0] local_osc_tune_word;
    logic preamp_on;
    logic [7:0] in_atten;
    logic [7:0] out_atten;
    logic bypass;
    logic amp_power;
    logic if_out_en;
    logic no_invert;
    logic analog_on;
    logic ext_ref_lock;
    logic backplane_ref_export;
    logic [15:0] ref_trim;
    logic auto_gain;
    logic auto_amp;
    logic [2:0] lin_mode;
    logic [7:0] in_level;
    logic [7:0] mix_level;
    logic [7:0] out_level;
  } dcd_cfg_s;

  typedef struct packed {
    logic req;
    logic we;
    logic factory;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dcd_nvm_s;

  typedef struct packed {
    logic [40:0] unused;
    logic auto_amp;
    logic auto_gain;
    logic preamp_on;
    logic spec_inverted;
    logic if_out_en;
    logic bypass;
    logic standby;
    logic [3:0] lo_misc;
    logic analog_on;
    logic ext_ref_lock;
    logic ref_detect;
    logic accessed;
    logic pad7;
    logic [1:0] loop_gain;
    logic [4:0] pll_lock;
  } dcd_status_s;

  localparam dcd_cfg_s CFG_DEFAULT = '{loop_gain: 2'h1, analog_on: 1'b1, default: '0};
  localparam dcd_nvm_s NVM_IDLE = '0;

  function automatic logic [2:0] payload_len(input logic [7:0] op);
    logic [2:0] n;
    n = LEN_0;
    unique case (op)
      OP_IN_TUNE, OP_OUT_TUNE, OP_LO_TUNE, OP_PAD: n = LEN_7;
      OP_ATTEN, OP_TRIM, OP_UNVM_WR, OP_FNVM_RD, OP_UNVM_RD: n = LEN_3;
      OP_GAIN: n = LEN_5;
      OP_REINIT, OP_INDIC, OP_SYNTH, OP_PREAMP, OP_ROUTE, OP_SAVE, OP_POWER, OP_REFSRC, OP_CAL,
      OP_Q_PARAM, OP_Q_TEMP, OP_Q_COND, OP_Q_IDENT: n = LEN_1;
      default: n = LEN_0;
    endcase
    return n;
  endfunction

endpackage

// ---- src/dcd_cfg_store.sv ----
`timescale 1ns/1ps
module dcd_cfg_store (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Write side
  input wire logic we,
  input dcd_pkg::dcd_cfg_s wdata,
  // Read side
  output dcd_pkg::dcd_cfg_s rdata_r
);

  // ****************************************
  // Startup state image
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= dcd_pkg::CFG_DEFAULT;
    end else if (we) begin
      rdata_r <= wdata;
    end
  end

endmodule

// ---- src/dcd_resp_shift.sv ----
`timescale 1ns/1ps
module dcd_resp_shift (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Load side
  input wire logic load,
  input wire logic [3:0] load_len,
  input wire logic [63:0] load_data,
  output logic busy,
  // Byte stream out
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);

  logic [63:0] buf_r;
  logic [3:0] cnt_r;

  // ****************************************
  // Most significant byte leaves first
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_r <= '0;
      cnt_r <= '0;
    end else if (load) begin
      buf_r <= load_data;
      cnt_r <= load_len;
    end else if (tx_valid && tx_ready) begin
      buf_r <= {buf_r[55:0], dcd_pkg::ACK_BYTE};
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign tx_data = buf_r[63:56];
  assign tx_valid = (cnt_r != 4'h0);
  assign busy = tx_valid;

endmodule

// ---- src/dcd_decoder.sv ----
`timescale 1ns/1ps
module dcd_decoder #(
  parameter logic [63:0] IDENT_SERIAL = 64'h0000_0000_0000_0000,  // Arbitrary value
  parameter logic [63:0] IDENT_REV = 64'h0000_0000_0000_0000,  // Arbitrary value
  parameter logic [63:0] IDENT_DATES = 64'h0000_0000_0000_0000  // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Command bytes in
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // Answer bytes out
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Settings applied to the hardware
  output dcd_pkg::dcd_cfg_s cfg,
  output logic ext_lock_go,
  output logic reprogram,
  output logic cal_start,
  // Nonvolatile memory port
  output dcd_pkg::dcd_nvm_s nvm,
  input wire logic nvm_ack,
  input wire logic [7:0] nvm_rdata,
  // Monitored state
  input wire logic ref_detect,
  input wire logic [4:0] pll_lock,
  input wire logic [31:0] temp_word
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [2:0] {
    S_ADDR = 3'b000,
    S_DATA = 3'b001,
    S_EXEC = 3'b010,
    S_NVM = 3'b011,
    S_RLOAD = 3'b100,
    S_WAIT = 3'b101
  } dcd_state_e;

  dcd_state_e state_r;
  logic [7:0] op_r;
  logic [2:0] len_r;
  logic [2:0] cnt_r;
  logic [55:0] frm_r;
  logic [2:0] rd_idx_r;
  logic [63:0] rd_buf_r;
  logic accessed_r;
  dcd_pkg::dcd_cfg_s cfg_r;
  dcd_pkg::dcd_cfg_s store_rd;
  dcd_pkg::dcd_nvm_s nvm_r;
  dcd_pkg::dcd_status_s status;
  logic store_we;
  logic rx_take;
  logic exec;
  logic is_cfg;
  logic is_query;
  logic is_nvm_rd;
  logic ld;
  logic [3:0] ld_len;
  logic [63:0] ld_data;
  logic [63:0] resp;
  logic busy;

  assign rx_take = rx_valid && rx_ready;
  assign exec = (state_r == S_EXEC);
  assign rx_ready = (state_r == S_ADDR) || (state_r == S_DATA);
  assign cfg = cfg_r;
  assign nvm = nvm_r;
  assign store_we = exec && (op_r == dcd_pkg::OP_SAVE);

  always_comb begin
    is_cfg = 1'b0;
    is_query = 1'b0;
    is_nvm_rd = 1'b0;
    unique case (op_r)
      dcd_pkg::OP_REINIT, dcd_pkg::OP_INDIC, dcd_pkg::OP_SYNTH, dcd_pkg::OP_IN_TUNE,
      dcd_pkg::OP_OUT_TUNE, dcd_pkg::OP_LO_TUNE, dcd_pkg::OP_PREAMP, dcd_pkg::OP_ATTEN,
      dcd_pkg::OP_ROUTE, dcd_pkg::OP_SAVE, dcd_pkg::OP_POWER, dcd_pkg::OP_REFSRC,
      dcd_pkg::OP_TRIM, dcd_pkg::OP_GAIN, dcd_pkg::OP_CAL: is_cfg = 1'b1;
      dcd_pkg::OP_Q_PARAM, dcd_pkg::OP_Q_TEMP, dcd_pkg::OP_Q_COND, dcd_pkg::OP_Q_IDENT: is_query = 1'b1;
      dcd_pkg::OP_FNVM_RD, dcd_pkg::OP_UNVM_RD: is_nvm_rd = 1'b1;
      default: is_cfg = 1'b0;
    endcase
  end

  // ****************************************
  // Framing by byte count
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_ADDR;
    end else begin
      unique case (state_r)
        S_ADDR: begin
          if (rx_take) begin
            state_r <= (dcd_pkg::payload_len(rx_data) == dcd_pkg::LEN_0) ? S_EXEC : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_take && (cnt_r + 3'h1 == len_r)) begin
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (is_nvm_rd || (op_r == dcd_pkg::OP_UNVM_WR)) begin
            state_r <= S_NVM;
          end else if (ld) begin
            state_r <= S_WAIT;
          end else begin
            state_r <= S_ADDR;
          end
        end
        S_NVM: begin
          if (nvm_ack && nvm_r.we) begin
            state_r <= S_WAIT;
          end else if (nvm_ack && (rd_idx_r == dcd_pkg::LAST_BYTE)) begin
            state_r <= S_RLOAD;
          end
        end
        S_RLOAD: state_r <= S_WAIT;
        S_WAIT: begin
          if (!busy) begin
            state_r <= S_ADDR;
          end
        end
        default: state_r <= S_ADDR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_r <= '0;
      len_r <= '0;
      cnt_r <= '0;
      frm_r <= '0;
    end else if (rx_take && (state_r == S_ADDR)) begin
      op_r <= rx_data;
      len_r <= dcd_pkg::payload_len(rx_data);
      cnt_r <= '0;
      frm_r <= '0;
    end else if (rx_take) begin
      frm_r <= {frm_r[47:0], rx_data};
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // ****************************************
  // Settings
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= dcd_pkg::CFG_DEFAULT;
    end else if (exec) begin
      unique case (op_r)
        dcd_pkg::OP_REINIT: begin
          if (frm_r[dcd_pkg::B_MODE]) begin
            cfg_r <= store_rd;
          end
        end
        dcd_pkg::OP_INDIC: cfg_r.indicator <= frm_r[dcd_pkg::B_MODE];
        dcd_pkg::OP_SYNTH: begin
          cfg_r.loop_gain <= frm_r[dcd_pkg::LG_LSB +: dcd_pkg::LG_W];
          cfg_r.fast_tune <= frm_r[dcd_pkg::B_FAST];
        end
        dcd_pkg::OP_IN_TUNE: cfg_r.input_tune_word <= frm_r;
        dcd_pkg::OP_OUT_TUNE: cfg_r.output_band_tune_word <= frm_r;
        dcd_pkg::OP_LO_TUNE: cfg_r.local_osc_tune_word <= frm_r;
        dcd_pkg::OP_PREAMP: cfg_r.preamp_on <= frm_r[dcd_pkg::B_MODE];
        dcd_pkg::OP_ATTEN: begin
          if (frm_r[dcd_pkg::ATT_TGT_LSB +: dcd_pkg::ATT_TGT_W] == dcd_pkg::ATT_IN) begin
            cfg_r.in_atten <= frm_r[dcd_pkg::BYTE_W-1:0];
          end else if (frm_r[dcd_pkg::ATT_TGT_LSB +: dcd_pkg::ATT_TGT_W] == dcd_pkg::ATT_OUT) begin
            cfg_r.out_atten <= frm_r[dcd_pkg::BYTE_W-1:0];
          end
        end
        dcd_pkg::OP_ROUTE: begin
          cfg_r.bypass <= frm_r[dcd_pkg::B_BYPASS];
          cfg_r.amp_power <= frm_r[dcd_pkg::B_AMPPWR];
          cfg_r.if_out_en <= frm_r[dcd_pkg::B_IFOUT];
          cfg_r.no_invert <= frm_r[dcd_pkg::B_NOINV];
        end
        dcd_pkg::OP_POWER: cfg_r.analog_on <= frm_r[dcd_pkg::B_MODE];
        dcd_pkg::OP_REFSRC: begin
          cfg_r.ext_ref_lock <= frm_r[dcd_pkg::B_EXTLOCK];
          cfg_r.backplane_ref_export <= frm_r[dcd_pkg::B_EXPORT];
        end
        dcd_pkg::OP_TRIM: cfg_r.ref_trim <= frm_r[dcd_pkg::WORD16_W-1:0];
        dcd_pkg::OP_GAIN: begin
          cfg_r.auto_gain <= frm_r[dcd_pkg::B_MODE];
          cfg_r.auto_amp <= frm_r[dcd_pkg::B_AUTOAMP];
          cfg_r.lin_mode <= frm_r[dcd_pkg::LIN_LSB +: dcd_pkg::LIN_W];
          cfg_r.in_level <= frm_r[dcd_pkg::LVL_IN_LSB +: dcd_pkg::BYTE_W];
          cfg_r.mix_level <= frm_r[dcd_pkg::LVL_MIX_LSB +: dcd_pkg::BYTE_W];
          cfg_r.out_level <= frm_r[dcd_pkg::LVL_OUT_LSB +: dcd_pkg::BYTE_W];
        end
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accessed_r <= 1'b0;
      reprogram <= 1'b0;
      cal_start <= 1'b0;
      ext_lock_go <= 1'b0;
    end else begin
      if (exec && (op_r == dcd_pkg::OP_INDIC)) begin
        accessed_r <= 1'b1;
      end
      reprogram <= exec && (op_r == dcd_pkg::OP_REINIT);
      cal_start <= exec && (op_r == dcd_pkg::OP_CAL);
      ext_lock_go <= cfg_r.ext_ref_lock && ref_detect;
    end
  end

  dcd_cfg_store u_store (
    .clk(clk),
    .arst_n(arst_n),
    .we(store_we),
    .wdata(cfg_r),
    .rdata_r(store_rd)
  );

  // ****************************************
  // Nonvolatile memory access
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_r <= dcd_pkg::NVM_IDLE;
      rd_idx_r <= '0;
      rd_buf_r <= '0;
    end else if (exec && (op_r == dcd_pkg::OP_UNVM_WR)) begin
      nvm_r.req <= 1'b1;
      nvm_r.we <= 1'b1;
      nvm_r.factory <= 1'b0;
      nvm_r.addr <= frm_r[dcd_pkg::NVM_ADDR_LSB +: dcd_pkg::WORD16_W];
      nvm_r.wdata <= frm_r[dcd_pkg::BYTE_W-1:0];
    end else if (exec && is_nvm_rd) begin
      nvm_r.req <= 1'b1;
      nvm_r.we <= 1'b0;
      nvm_r.factory <= (op_r == dcd_pkg::OP_FNVM_RD);
      nvm_r.addr <= frm_r[dcd_pkg::WORD16_W-1:0];
      nvm_r.wdata <= '0;
      rd_idx_r <= '0;
    end else if ((state_r == S_NVM) && nvm_ack) begin
      rd_buf_r[rd_idx_r * dcd_pkg::BYTE_W +: dcd_pkg::BYTE_W] <= nvm_rdata;
      rd_idx_r <= rd_idx_r + 3'h1;
      nvm_r.addr <= nvm_r.addr + 16'h0001;
      if (nvm_r.we || (rd_idx_r == dcd_pkg::LAST_BYTE)) begin
        nvm_r.req <= 1'b0;
      end
    end
  end

  // ****************************************
  // Answers
  // ****************************************
  always_comb begin
    status = '0;
    status.pll_lock = pll_lock;
    status.loop_gain = cfg_r.loop_gain;
    status.accessed = accessed_r;
    status.ref_detect = ref_detect;
    status.ext_ref_lock = cfg_r.ext_ref_lock;
    status.analog_on = cfg_r.analog_on;
    status.standby = !cfg_r.analog_on;
    status.bypass = cfg_r.bypass;
    status.if_out_en = cfg_r.if_out_en;
    status.spec_inverted = !cfg_r.no_invert;
    status.preamp_on = cfg_r.preamp_on;
    status.auto_gain = cfg_r.auto_gain;
    status.auto_amp = cfg_r.auto_amp;
  end

  always_comb begin
    resp = '0;
    unique case (op_r)
      dcd_pkg::OP_Q_PARAM: begin
        unique case (frm_r[dcd_pkg::QSEL_W-1:0])
          dcd_pkg::QP_IN: resp[dcd_pkg::TUNE_W-1:0] = cfg_r.input_tune_word;
          dcd_pkg::QP_OUT: resp[dcd_pkg::TUNE_W-1:0] = cfg_r.output_band_tune_word;
          dcd_pkg::QP_LO: resp[dcd_pkg::TUNE_W-1:0] = cfg_r.local_osc_tune_word;
          dcd_pkg::QP_OTHER: resp[23:0] = {3'h0, 1'b0, !cfg_r.no_invert, cfg_r.if_out_en,
                                           cfg_r.amp_power, cfg_r.bypass, cfg_r.in_atten, cfg_r.out_atten};
          default: resp = '0;
        endcase
      end
      dcd_pkg::OP_Q_TEMP: resp[31:0] = temp_word;
      dcd_pkg::OP_Q_COND: resp = status;
      dcd_pkg::OP_Q_IDENT: begin
        unique case (frm_r[dcd_pkg::QSEL_W-1:0])
          dcd_pkg::QI_SERIAL: resp = IDENT_SERIAL;
          dcd_pkg::QI_REV: resp = IDENT_REV;
          dcd_pkg::QI_DATES: resp = IDENT_DATES;
          default: resp = '0;
        endcase
      end
      default: resp = '0;
    endcase
  end

  always_comb begin
    ld = 1'b0;
    ld_len = dcd_pkg::ANS_ACK;
    ld_data = {dcd_pkg::ACK_BYTE, 56'h0};
    if (exec && is_cfg) begin
      ld = 1'b1;
    end else if (exec && is_query) begin
      ld = 1'b1;
      ld_len = dcd_pkg::ANS_RESP;
      ld_data = resp;
    end else if ((state_r == S_NVM) && nvm_ack && nvm_r.we) begin
      ld = 1'b1;
    end else if (state_r == S_RLOAD) begin
      ld = 1'b1;
      ld_len = dcd_pkg::ANS_RESP;
      ld_data = rd_buf_r;
    end
  end

  dcd_resp_shift u_shift (
    .clk(clk),
    .arst_n(arst_n),
    .load(ld),
    .load_len(ld_len),
    .load_data(ld_data),
    .busy(busy),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

endmodule

// ---- verification/dcd_decoder_properties.sv ----
`timescale 1ns/1ps
module dcd_decoder_properties (
  // Clock, reset
  input wire logic clk,
  input wire logic arst_n,
  // Watched ports
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input dcd_pkg::dcd_cfg_s cfg,
  input wire logic ext_lock_go,
  input wire logic reprogram,
  input wire logic cal_start,
  input dcd_pkg::dcd_nvm_s nvm,
  input wire logic nvm_ack,
  input wire logic ref_detect
);
  // ***
  // Checks
  // ***
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  AST_LOCK: assert property (ext_lock_go |-> $past(ref_detect) && $past(cfg.ext_ref_lock))
    else $error("lock without reference");
  AST_BUSY: assert property (tx_valid |-> !rx_ready)
    else $error("input open while answering");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("answer byte lost");
  AST_PULSE: assert property (reprogram |=> !reprogram)
    else $error("reprogram too long");
  AST_CAL: assert property (cal_start |-> ##[0:2] tx_valid && tx_data == dcd_pkg::ACK_BYTE)
    else $error("calibrate not acked");
  AST_NVM: assert property (nvm.req && !nvm_ack |=> nvm.req && $stable(nvm.addr) && $stable(nvm.we))
    else $error("memory request dropped");
  AST_NVM_WAIT: assert property (nvm.req |-> !rx_ready && !tx_valid)
    else $error("answer during memory access");
  AST_QUIET: assert property (!$stable(cfg) |-> !rx_ready)
    else $error("settings changed while idle");
  AST_ACK: assert property ($rose(tx_valid) |-> !$past(rx_ready))
    else $error("answer without command");
  cover property (reprogram);
  cover property (cal_start);
  cover property (nvm.req && nvm_ack);
endmodule

bind dcd_decoder dcd_decoder_properties i_props (.clk, .arst_n, .rx_ready, .tx_valid, .tx_ready, .tx_data, .cfg,
  .ext_lock_go, .reprogram, .cal_start, .nvm, .nvm_ack, .ref_detect);

// ---- verification/dcd_nvm_model.sv ----
`timescale 1ns/1ps
module dcd_nvm_model (
  // Clock, mode
  input wire logic clk,
  input wire logic slow,
  // Memory port
  input dcd_pkg::dcd_nvm_s nvm,
  output logic nvm_ack,
  output logic [7:0] nvm_rdata
);
  // ***
  // Memory
  // ***
  logic [7:0] um [logic [15:0]];
  int w = 0;
  initial nvm_ack = 1'h0;
  initial nvm_rdata = 8'h00;
  always @(posedge clk) begin
    nvm_ack <= 1'h0;
    nvm_rdata <= ~nvm_rdata;
    if (nvm.req && !nvm_ack && ++w > 4 * slow) begin
      w = 0;
      nvm_ack <= 1'h1;
      nvm_rdata <= nvm.factory ? nvm.addr[7:0] ^ 8'hA5 :
        um.exists(nvm.addr) ? um[nvm.addr] : nvm.addr[7:0] ^ 8'h3C;
      if (nvm.we) um[nvm.addr] = nvm.wdata;
    end
  end
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic clk, arst_n, rx_valid, rx_ready, tx_valid, tx_ready, ext_lock_go, reprogram, cal_start, nvm_ack;
  logic ref_detect, slow;
  logic [7:0] rx_data, tx_data, nvm_rdata, b;
  logic [4:0] pll_lock;
  logic [31:0] temp_word, seed, r;
  logic [63:0] v, g;
  logic [15:0] a;
  logic [8:0] e;
  logic [8:0] q[$];
  int errors, checks_done, nrep, ncal, cyc;
  dcd_pkg::dcd_cfg_s cfg;
  dcd_pkg::dcd_nvm_s nvm;
  localparam logic [63:0] SER = 64'h0123_4567_89AB_CDEF; // Arbitrary
  localparam logic [63:0] REV = 64'h5566_7788_99AA_BBCC; // Arbitrary
  localparam logic [63:0] DAT = 64'h0F1E_2D3C_4B5A_6978; // Arbitrary
  dcd_decoder #(.IDENT_SERIAL(SER), .IDENT_REV(REV), .IDENT_DATES(DAT)) i_dut (.clk, .arst_n, .rx_data,
    .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .cfg, .ext_lock_go, .reprogram, .cal_start, .nvm,
    .nvm_ack, .nvm_rdata, .ref_detect, .pll_lock, .temp_word);
  dcd_nvm_model i_mem (.clk, .slow, .nvm, .nvm_ack, .nvm_rdata);
  // ***
  // Helpers
  // ***
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [319:0] got, input logic [319:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Sends one frame, queues the expected answer, waits until it is drained
  task automatic cmd(input logic [7:0] op, input logic [63:0] val, input int n, input int na,
                     input logic [63:0] ans, input logic [7:0] dc);
    for (int i = na - 1; i >= 0; i--) q.push_back({dc[i], ans[8 * i +: 8]});
    tick(1);
    rx_valid = 1'h1;
    for (int i = n; i >= 0; i--) begin
      rx_data = (i == n) ? op : val[8 * i +: 8];
      while (rx_ready !== 1'h1) tick(1);
      tick(1);
    end
    rx_valid = 1'h0;
    rx_data = ~rx_data;
    while (q.size() > 0 || tx_valid !== 1'h0 || rx_ready !== 1'h1) tick(1);
  endtask
  task automatic w(input logic [7:0] op, input logic [63:0] val, input int n);
    cmd(op, val, n, 1, {56'h0, dcd_pkg::ACK_BYTE}, 8'h00);
  endtask
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Consumer stalls at random and compares each byte it takes, except bytes queued as don't-care
  always @(posedge clk) begin
    #1;
    r = rnd();
    tx_ready = r[0] | r[1];
    if (++cyc > 20000) begin
      errors++;
      give_verdict();
    end
    if (reprogram === 1'h1) nrep++;
    if (cal_start === 1'h1) ncal++;
    if (tx_valid === 1'h1 && tx_ready) begin
      if (q.size() == 0) chk(1, 0);
      else begin
        e = q.pop_front();
        if (!e[8]) chk(tx_data, e[7:0]);
      end
    end
  end
  initial begin
    seed = 32'h0001_8666;
    {arst_n, rx_valid, rx_data, tx_ready, ref_detect, slow} = '0;
    pll_lock = 5'h16;
    temp_word = 32'h4120_0000;
    tick(12);
    arst_n = 1'h1;
    chk({cfg, nvm, rx_ready, tx_valid}, {dcd_pkg::CFG_DEFAULT, dcd_pkg::NVM_IDLE, 2'h2});
    for (int k = 0; k < 3; k++) begin
      v = {8'h00, 24'(rnd()), rnd()};
      w(8'h10 + 8'(k), v, 7);
      cmd(8'h30, 64'(k), 1, 8, v, 8'h00);
      b = 8'(rnd());
      w(8'h02, b, 1);
      w(8'h03, {b[7:2], 2'(k)}, 1);
      w(8'h14, b, 1);
      w(8'h16, b, 1);
      w(8'h19, b, 1);
      w(8'h1A, b, 1);
      chk({cfg.indicator, cfg.loop_gain, cfg.fast_tune, cfg.preamp_on, cfg.bypass, cfg.amp_power, cfg.if_out_en,
        cfg.no_invert, cfg.analog_on, cfg.ext_ref_lock, cfg.backplane_ref_export},
        {b[0], 2'(k), b[2], b[0], b[0], b[1], b[2], b[3], b[0], b[0], b[1]});
    end
    $display("tune and switch test done");
    v = {rnd(), rnd()};
    w(8'h15, {v[63:51], 3'h0, v[7:0]}, 3);
    w(8'h15, {v[63:51], 3'h1, v[15:8]}, 3);
    w(8'h15, {v[63:51], 3'h2, v[23:16]}, 3);
    cmd(8'h30, 64'h3, 1, 8, {44'h0, ~b[3], b[2:0], v[7:0], v[15:8]}, 8'h00);
    w(8'h1B, v[39:16], 3);
    g = {rnd(), rnd()};
    w(8'h1D, {g[39:5], 3'h5, g[1:0]}, 5);
    chk({cfg.ref_trim, cfg.auto_gain, cfg.auto_amp, cfg.lin_mode, cfg.in_level, cfg.mix_level, cfg.out_level},
      {v[31:16], g[0], g[1], 3'h5, g[15:8], g[23:16], g[31:24]});
    $display("level test done");
    w(8'h1A, 64'h1, 1);
    tick(3);
    chk(ext_lock_go, 1'h0);
    ref_detect = 1'h1;
    tick(3);
    chk(ext_lock_go, 1'h1);
    w(8'h02, 64'h1, 1);
    w(8'h18, 64'h0, 1);
    w(8'h02, 64'h0, 1);
    w(8'h01, 64'hFE, 1);
    chk({cfg.indicator, 8'(nrep)}, 9'h001);
    w(8'h01, 64'h1, 1);
    chk({cfg.indicator, 8'(nrep)}, 9'h102);
    w(8'h1F, 64'h0, 1);
    chk(ncal, 1);
    $display("image test done");
    arst_n = 1'h0;
    tick(1);
    arst_n = 1'h1;
    chk({cfg, nvm, rx_ready, tx_valid}, {dcd_pkg::CFG_DEFAULT, dcd_pkg::NVM_IDLE, 2'h2});
    w(8'h01, 64'h1, 1);
    chk(cfg, dcd_pkg::CFG_DEFAULT);
    cmd(8'h05, 64'h0, 0, 0, 64'h0, 8'h00);
    cmd(8'h36, 64'h0, 7, 0, 64'h0, 8'h00);
    cmd(8'h32, 64'h0, 1, 8, {40'h0, 8'h08, 8'h0A, 3'h1, pll_lock}, 8'hF8);
    cmd(8'h31, 64'h0, 1, 8, {32'h0, temp_word}, 8'hF0);
    for (int k = 0; k < 4; k++) begin
      cmd(8'h33, 64'(k), 1, 8, k == 0 ? SER : k == 1 ? REV : k == 2 ? DAT : 64'h0, 8'h00);
    end
    $display("query test done");
    for (int f = 0; f < 2; f++) begin
      slow = f[0];
      a = 16'(rnd());
      b = 8'(rnd());
      w(8'h1C, {a, b}, 3);
      for (int i = 0; i < 8; i++) v[8 * i +: 8] = 8'(a + i) ^ (f ? 8'hA5 : 8'h3C);
      if (f == 0) v[7:0] = b;
      cmd(f ? 8'h34 : 8'h35, a, 3, 8, v, 8'h00);
    end
    $display("memory test done");
    give_verdict();
  end
endmodule
